// File: bench/pfsa_link_sva.sv
// Purpose: timing checks on the link between core end and sequencer
// Assumes: one clock domain, asynchronous active-high reset
// Notes: sees only the link signals, not the command side
`timescale 1ns/1ps

module pfsa_link_sva #(
  parameter int PROG_CYCLES = 5
) (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                reset,
  // link signals
  input wire logic                regWr,
  input wire logic                regRd,
  input wire pfsa_pkg::pfsa_sel_t regSel,
  input wire logic [7:0]          regWdata,
  input wire logic [7:0]          regRdata,
  input wire logic                rdValid,
  input wire logic                coreStall
);
  import pfsa_pkg::*;

  logic [15:0] stallCnt;
  logic        trigRd;
  logic        trigWr;
  logic        rdTaken;
  logic        unlockAa;

  assign rdTaken  = regRd && !coreStall;
  assign trigRd   = regWr && !coreStall && regSel == PFSA_CTRL
                    && regWdata[0] && regWdata[7];
  assign trigWr   = regWr && !coreStall && regSel == PFSA_CTRL
                    && regWdata[1];
  assign unlockAa = regWr && regSel == PFSA_UNLOCK && regWdata == 8'haa;

  // a counter, since the stall is far longer than a repetition may span
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      stallCnt <= 16'h0;
    else if (coreStall)
      stallCnt <= stallCnt + 16'h1;
    else
      stallCnt <= 16'h0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_read_answer: assert property (rdTaken |=> rdValid)
    else $error("read taken without answer next cycle");
  a_valid_cause: assert property (rdValid |-> $past(rdTaken))
    else $error("read answer without a taken read");
  a_read_idle: assert property (trigRd |=> !(regWr || regRd) [*2])
    else $error("access within two cycles of read trigger");
  a_rdata_hold: assert property (!rdValid |-> $stable(regRdata))
    else $error("read byte changed without a read");
  a_no_valid_stall: assert property (coreStall |-> ##1 !rdValid)
    else $error("read answered during stall");
  a_stall_cause: assert property ($rose(coreStall) |-> $past(trigWr, 3))
    else $error("stall without write trigger three cycles before");
  a_held_access: assert property (coreStall && (regWr || regRd) |=>
      $stable({regWr, regRd, regSel, regWdata}))
    else $error("stalled access not held");
  a_unlock_before: assert property (
      $rose(coreStall) |-> $past(unlockAa, 4))
    else $error("write started without unlock pattern");
  a_write_idle: assert property (trigWr |=>
      (!regWr && !regRd) ##1 (!regWr && !regRd))
    else $error("access within two cycles of write trigger");
  a_hi_clear: assert property (rdValid && $past(regSel) == PFSA_DATA_HI
      |-> regRdata[7:6] == 2'h0)
    else $error("upper data bits not zero");
  a_stall_length: assert property (
      $fell(coreStall) |-> stallCnt == PROG_CYCLES)
    else $error("stall length wrong");
  a_stall_bound: assert property (stallCnt <= PROG_CYCLES)
    else $error("stall too long");

endmodule : pfsa_link_sva

// File: bench/tb_program_flash_self_access.sv
// Purpose: end-to-end bench for core end and sequencer, plus rule breaker
// Assumes: second sequencer is driven directly to make refusals
// Notes: flash is never reset, so only written words are read back
`timescale 1ns/1ps

module tb_program_flash_self_access;
  import pfsa_pkg::*;

  localparam int PROG = 5;

  logic        core_clk, reset, cmdValid, cmdWrite, cmdReady, rspValid;
  logic [12:0] cmdAddr, addrB;
  logic [13:0] cmdData, rspData, wB, wordW, wordV;
  logic        protA, protB, busyA, busyB, blkA, blkB, prevBusyB, prevBusyA;
  logic [15:0] rdQ[$], rdQB[$], blkQ[$], blkQA[$];
  logic [13:0] mem[int];
  logic [12:0] a;
  int          err_total, comparisons, seed;
  // rows: ctrl before, unlock bytes, stray write between, protect, refused
  logic [7:0]  rowCtl[5] = '{8'h84, 8'h80, 8'h84, 8'h84, 8'h84};
  logic [7:0]  rowU1[5]  = '{8'h55, 8'h55, 8'haa, 8'h55, 8'h55};
  logic [7:0]  rowU2[5]  = '{8'haa, 8'haa, 8'h55, 8'haa, 8'haa};
  logic        rowMid[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic        rowPro[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic        rowBlk[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  pfsa_link_if lnk ();
  pfsa_link_if lnkB ();

  pfsa_core_host i_pfsa_core_host (.core_clk(core_clk), .reset(reset),
    .link(lnk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData));
  pfsa_device #(.PROG_CYCLES(PROG)) i_pfsa_device (.core_clk(core_clk),
    .reset(reset), .link(lnk), .writeProtectCfg(protA),
    .progBusy(busyA), .writeBlocked(blkA));
  // second sequencer faces the bench, which breaks the unlock on purpose
  pfsa_device #(.PROG_CYCLES(PROG)) i_pfsa_device_b (.core_clk(core_clk),
    .reset(reset), .link(lnkB), .writeProtectCfg(protB),
    .progBusy(busyB), .writeBlocked(blkB));
  pfsa_link_sva #(.PROG_CYCLES(PROG)) i_pfsa_link_sva (
    .core_clk(core_clk), .reset(reset), .regWr(lnk.regWr),
    .regRd(lnk.regRd), .regSel(lnk.regSel), .regWdata(lnk.regWdata),
    .regRdata(lnk.regRdata), .rdValid(lnk.rdValid),
    .coreStall(lnk.coreStall));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // command to the core end; reads note the expected word first
  task automatic cmd(input logic wr, input logic [12:0] ad,
                     input logic [13:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmdReady !== 1'b1 && n < 3000) begin
      n++;
      @(negedge core_clk);
    end
    if (!wr)
      rdQ.push_back({2'h0, mem[ad]});
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr  <= ad;
    cmdData  <= d;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    if (wr && protA)
      mem[ad] = d;
  endtask : cmd

  // one register access on the second link, held while stalled
  task automatic acc(input logic rd, input pfsa_sel_t s,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    lnkB.regWr    <= !rd;
    lnkB.regRd    <= rd;
    lnkB.regSel   <= s;
    lnkB.regWdata <= d;
    @(negedge core_clk);
    while (lnkB.coreStall !== 1'b0 && n < 500) begin
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    lnkB.regWr <= 1'b0;
    lnkB.regRd <= 1'b0;
  endtask : acc

  always @(negedge core_clk) begin
    if (rspValid === 1'b1)
      check({2'h0, rspData}, rdQ.size() != 0 ? rdQ.pop_front() : 'x);
    if (lnkB.rdValid === 1'b1)
      check({8'h0, lnkB.regRdata},
            rdQB.size() != 0 ? rdQB.pop_front() : 'x);
    if (blkB === 1'b1)
      check(16'h1, blkQ.size() != 0 ? blkQ.pop_front() : 'x);
    if (busyB === 1'b1 && prevBusyB !== 1'b1)
      check(16'h0, blkQ.size() != 0 ? blkQ.pop_front() : 'x);
    prevBusyB = busyB;
    if (blkA === 1'b1)
      check(16'h1, blkQA.size() != 0 ? blkQA.pop_front() : 'x);
    if (busyA === 1'b1 && prevBusyA !== 1'b1)
      check(16'h0, blkQA.size() != 0 ? blkQA.pop_front() : 'x);
    prevBusyA = busyA;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = 13'h0;
    cmdData = 14'h0;
    protA = 1'b1;
    protB = 1'b1;
    prevBusyB = 1'b0;
    prevBusyA = 1'b0;
    lnkB.regWr = 1'b0;
    lnkB.regRd = 1'b0;
    lnkB.regSel = PFSA_CTRL;
    lnkB.regWdata = 8'h0;
    err_total = 0;
    comparisons = 0;
    seed = $urandom(32'he101);
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    // edge addresses and random ones, written then read back
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 13'h0 : (i == 1) ? 13'h7ff : 13'($urandom_range(2046, 1));
      blkQA.push_back(16'h0);
      cmd(1'b1, a, 14'($urandom));
      cmd(1'b0, a, 14'h0);
    end
    @(posedge core_clk);
    protA <= 1'b0;
    blkQA.push_back(16'h1);
    cmd(1'b1, 13'h0, ~mem[0]);
    cmd(1'b0, 13'h0, 14'h0);
    @(posedge core_clk);
    protA <= 1'b1;
    // one good write, then refused writes (write enable, unlock, protect) that must leave it alone
    addrB = 13'($urandom_range(2047, 0));
    wordW = 14'($urandom);
    wordV = ~wordW;
    for (int i = 0; i < 5; i++) begin
      wB = (i == 0) ? wordW : wordV;
      acc(1'b0, PFSA_ADDR_LO, addrB[7:0]);
      acc(1'b0, PFSA_ADDR_HI, {3'h0, addrB[12:8]});
      acc(1'b0, PFSA_DATA_LO, wB[7:0]);
      acc(1'b0, PFSA_DATA_HI, {2'h0, wB[13:8]});
      @(posedge core_clk);
      protB <= rowPro[i];
      acc(1'b0, PFSA_CTRL, rowCtl[i]);
      acc(1'b0, PFSA_UNLOCK, rowU1[i]);
      if (rowMid[i])
        acc(1'b0, PFSA_CTRL, rowCtl[i]);
      acc(1'b0, PFSA_UNLOCK, rowU2[i]);
      blkQ.push_back({15'h0, rowBlk[i]});
      acc(1'b0, PFSA_CTRL, 8'h86);
      repeat (2) @(posedge core_clk);
      acc(1'b0, PFSA_CTRL, 8'h80);
    end
    @(posedge core_clk);
    protB <= 1'b1;
    acc(1'b0, PFSA_CTRL, 8'h81);
    @(posedge core_clk);
    rdQB.push_back({8'h0, wordW[7:0]});
    acc(1'b1, PFSA_DATA_LO, 8'h0);
    rdQB.push_back({10'h0, wordW[13:8]});
    acc(1'b1, PFSA_DATA_HI, 8'h0);
    // an address change alone must not disturb the fetched word
    acc(1'b0, PFSA_ADDR_LO, ~addrB[7:0]);
    rdQB.push_back({8'h0, wordW[7:0]});
    acc(1'b1, PFSA_DATA_LO, 8'h0);
    repeat (40) @(posedge core_clk);
    check(16'(rdQ.size() + rdQB.size() + blkQ.size() + blkQA.size()),
          16'h0);
    summarize();
  end

endmodule : tb_program_flash_self_access

// File: verilog/pfsa_consts.svh
// Purpose: constants for the program flash self-access sequencer
// Assumes: one access on the link equals one instruction cycle
// Notes: selector codes and control bit positions are local choices
//
// Functional notes
// - read fills data pair after two cycles
// - data pair holds until read or write
// - firmware loads address, selects flash, triggers read
// - core stalls during program write
// - core resumes after second idle cycle
// - cleared protect config blocks all writes
// - write trigger needs earlier write enable
// - clearing write enable never aborts write
// - unlock 55h then AAh precedes trigger
// - five-step unlock runs uninterrupted, interrupts off
// - two idle cycles follow write trigger
// - write carries 14-bit word from pair
// - address stays inside implemented memory
// - write enable kept clear outside writes
`ifndef PFSA_CONSTS_SVH
`define PFSA_CONSTS_SVH

// register selectors on the link
`define PFSA_SEL_ADDR_LO   3'h0
`define PFSA_SEL_ADDR_HI   3'h1
`define PFSA_SEL_DATA_LO   3'h2
`define PFSA_SEL_DATA_HI   3'h3
`define PFSA_SEL_CTRL      3'h4
`define PFSA_SEL_UNLOCK    3'h5

// control register bit positions
`define PFSA_BIT_RD        0
`define PFSA_BIT_WR        1
`define PFSA_BIT_WRITE_ENABLE_BIT      2
`define PFSA_BIT_PSS       7

// unlock pattern
`define PFSA_UNLOCK_FIRST  8'h55
`define PFSA_UNLOCK_SECOND 8'haa

// geometry and reset values
`define PFSA_MEM_WORDS     2048
`define PFSA_ADDR_HI_BITS  5
`define PFSA_DATA_HI_BITS  6
`define PFSA_RESET_BYTE    8'h00

// timing
`define PFSA_CLK_PERIOD_NS 10
`define PFSA_READ_CYCLES   2
`define PFSA_SETUP_CYCLES  2
`define PFSA_PROG_TIME_NS  2000
`define PFSA_PROG_CYCLES \
  ((`PFSA_PROG_TIME_NS + `PFSA_CLK_PERIOD_NS - 1) / `PFSA_CLK_PERIOD_NS)

`endif

// File: verilog/pfsa_core_host.sv
// Purpose: core end that runs read and write sequences on the link
// Assumes: one command at a time, taken while cmdReady is high
// Notes: interrupts are not modelled; the sequence is never broken
`timescale 1ns/1ps
`include "pfsa_consts.svh"

module pfsa_core_host (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // link to the sequencer
  pfsa_link_if.core        link,
  // command side
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [12:0] cmdAddr,
  input  wire logic [13:0] cmdData,
  output logic             cmdReady,
  output logic             rspValid,
  output logic [13:0]      rspData
);
  import pfsa_pkg::*;

  logic        busy;
  logic        isWrite;
  logic [3:0]  step;
  logic [12:0] addr;
  logic [13:0] wdata;
  pfsa_sel_t   pendSel;
  pfsa_act_t   act;

  function automatic pfsa_act_t stepAct(
    input logic        wrSeq,
    input logic [3:0]  idx,
    input logic [12:0] a,
    input logic [13:0] d
  );
    pfsa_act_t r;
    logic [7:0] ctl;
    r = '{PFSA_OP_NOP, PFSA_CTRL, `PFSA_RESET_BYTE};
    ctl = `PFSA_RESET_BYTE;
    ctl[`PFSA_BIT_PSS] = 1'b1;
    if (!wrSeq) begin
      ctl[`PFSA_BIT_RD] = 1'b1;
      unique case (idx)
        4'h0: r = '{PFSA_OP_WR, PFSA_ADDR_LO, a[7:0]};
        4'h1: r = '{PFSA_OP_WR, PFSA_ADDR_HI, {3'h0, a[12:8]}};
        4'h2: r = '{PFSA_OP_WR, PFSA_CTRL, ctl};
        4'h5: r = '{PFSA_OP_RD, PFSA_DATA_LO, 8'h00};
        4'h6: r = '{PFSA_OP_RD, PFSA_DATA_HI, 8'h00};
        4'h8: r.op = PFSA_OP_DONE;
        default: r.op = PFSA_OP_NOP;
      endcase
    end else begin
      ctl[`PFSA_BIT_WRITE_ENABLE_BIT] = 1'b1;
      unique case (idx)
        4'h0: r = '{PFSA_OP_WR, PFSA_ADDR_LO, a[7:0]};
        4'h1: r = '{PFSA_OP_WR, PFSA_ADDR_HI, {3'h0, a[12:8]}};
        4'h2: r = '{PFSA_OP_WR, PFSA_DATA_LO, d[7:0]};
        4'h3: r = '{PFSA_OP_WR, PFSA_DATA_HI, {2'h0, d[13:8]}};
        4'h4: r = '{PFSA_OP_WR, PFSA_CTRL, ctl};
        4'h5: r = '{PFSA_OP_WR, PFSA_UNLOCK, `PFSA_UNLOCK_FIRST};
        4'h7: r = '{PFSA_OP_WR, PFSA_UNLOCK, `PFSA_UNLOCK_SECOND};
        4'h8: begin
          ctl[`PFSA_BIT_WR] = 1'b1;
          r = '{PFSA_OP_WR, PFSA_CTRL, ctl};
        end
        4'h9: r.op = PFSA_OP_NOP;
        4'hb: begin
          ctl[`PFSA_BIT_WRITE_ENABLE_BIT] = 1'b0;
          r = '{PFSA_OP_WR, PFSA_CTRL, ctl};
        end
        4'hc: r.op = PFSA_OP_DONE;
        default: r.op = PFSA_OP_NOP;
      endcase
    end
    return r;
  endfunction : stepAct

  assign act = stepAct(isWrite, step, addr, wdata);

  // sequence control; a stalled access is held, not repeated
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      isWrite <= 1'b0;
      step <= 4'h0;
      addr <= 13'h0000;
      wdata <= 14'h0000;
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      link.regWr <= 1'b0;
      link.regRd <= 1'b0;
      link.regSel <= PFSA_CTRL;
      link.regWdata <= `PFSA_RESET_BYTE;
    end else begin
      rspValid <= 1'b0;
      if (!busy) begin
        cmdReady <= 1'b1;
        if (cmdValid && cmdReady) begin
          busy <= 1'b1;
          cmdReady <= 1'b0;
          isWrite <= cmdWrite;
          addr <= cmdAddr;
          wdata <= cmdData;
          step <= 4'h0;
        end
      end else if (!link.coreStall) begin
        link.regWr <= (act.op == PFSA_OP_WR);
        link.regRd <= (act.op == PFSA_OP_RD);
        link.regSel <= act.sel;
        link.regWdata <= act.data;
        step <= step + 4'h1;
        if (act.op == PFSA_OP_DONE) begin
          busy <= 1'b0;
          rspValid <= !isWrite;
        end
      end
    end
  end

  // read answers arrive one cycle after the read is taken
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pendSel <= PFSA_DATA_LO;
      rspData <= 14'h0000;
    end else begin
      if (link.regRd && !link.coreStall) pendSel <= link.regSel;
      if (link.rdValid) begin
        if (pendSel == PFSA_DATA_LO) rspData[7:0] <= link.regRdata;
        else rspData[13:8] <= link.regRdata[5:0];
      end
    end
  end

endmodule : pfsa_core_host

// File: verilog/pfsa_device.sv
// Purpose: program flash self-access sequencer with its flash array
// Assumes: link accesses are taken only while coreStall is low
// Notes: flash contents have no reset; data eeprom space not modelled
`timescale 1ns/1ps
`include "pfsa_consts.svh"

module pfsa_device #(
  parameter int MEM_WORDS   = `PFSA_MEM_WORDS,
  parameter int PROG_CYCLES = `PFSA_PROG_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // link from the core
  pfsa_link_if.dev  link,
  // configuration and status
  input  wire logic writeProtectCfg,
  output logic      progBusy,
  output logic      writeBlocked
);
  import pfsa_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);
  localparam int DH = `PFSA_DATA_HI_BITS;
  localparam int AH = `PFSA_ADDR_HI_BITS;
  localparam logic [15:0] READ_LAST  = 16'(`PFSA_READ_CYCLES - 1);
  localparam logic [15:0] SETUP_LAST = 16'(`PFSA_SETUP_CYCLES - 1);
  localparam logic [15:0] PROG_LAST  = 16'(PROG_CYCLES - 1);

  // programmer-visible state
  logic [7:0]    addressLow;
  logic [AH-1:0] addressHigh;
  logic [7:0]    dataLow;
  logic [DH-1:0] dataHigh;
  logic          programSpaceSelect;
  logic          writeEnableBit;
  logic          readTrigger;
  logic          writeTrigger;

  // sequencer state
  pfsa_state_t   state;
  pfsa_unlock_t  unlockState;
  logic [15:0]   cnt;
  logic [13:0]   flashMem [MEM_WORDS];

  // decoded events
  logic          wrTaken;
  logic          rdTaken;
  logic          ctrlWrite;
  logic          startRead;
  logic          startWrite;
  logic          tryWrite;
  logic          readDone;
  logic          progDone;
  logic [AH+7:0] fullAddress;
  logic [AW-1:0] wordIndex;

  function automatic logic [7:0] readMux(
    input pfsa_sel_t sel,
    input logic [7:0] aLo,
    input logic [AH-1:0] aHi,
    input logic [7:0] dLo,
    input logic [DH-1:0] dHi,
    input logic [7:0] ctl
  );
    logic [7:0] r;
    r = `PFSA_RESET_BYTE;
    unique case (sel)
      PFSA_ADDR_LO: r = aLo;
      PFSA_ADDR_HI: r = {{(8 - AH){1'b0}}, aHi};
      PFSA_DATA_LO: r = dLo;
      PFSA_DATA_HI: r = {{(8 - DH){1'b0}}, dHi};
      PFSA_CTRL:    r = ctl;
      PFSA_UNLOCK:  r = `PFSA_RESET_BYTE;
      default:      r = `PFSA_RESET_BYTE;
    endcase
    return r;
  endfunction : readMux

  function automatic logic [7:0] ctrlByte(
    input logic pss,
    input logic write_enable_bit,
    input logic wr,
    input logic rd
  );
    logic [7:0] r;
    r = `PFSA_RESET_BYTE;
    r[`PFSA_BIT_PSS] = pss;
    r[`PFSA_BIT_WRITE_ENABLE_BIT] = write_enable_bit;
    r[`PFSA_BIT_WR] = wr;
    r[`PFSA_BIT_RD] = rd;
    return r;
  endfunction : ctrlByte

  assign wrTaken = link.regWr && !link.coreStall;
  assign rdTaken = link.regRd && !link.coreStall;
  assign ctrlWrite = wrTaken && (link.regSel == PFSA_CTRL);
  // addresses past the array wrap onto its low bits
  assign fullAddress = {addressHigh, addressLow};
  assign wordIndex = fullAddress[AW-1:0];

  assign startRead = ctrlWrite && (state == PFSA_IDLE)
                     && link.regWdata[`PFSA_BIT_RD]
                     && link.regWdata[`PFSA_BIT_PSS];

  // write enable is the stored bit, so setting both at once from a clear enable fails
  assign tryWrite = ctrlWrite && link.regWdata[`PFSA_BIT_WR]
                    && !writeTrigger;
  assign startWrite = tryWrite && (state == PFSA_IDLE)
                      && writeEnableBit
                      && (unlockState == PFSA_GOT_AA)
                      && link.regWdata[`PFSA_BIT_PSS]
                      && writeProtectCfg;

  assign readDone = (state == PFSA_READ) && (cnt == 16'h0000);
  assign progDone = (state == PFSA_PROG) && (cnt == 16'h0000);

  // address pair
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      addressLow <= `PFSA_RESET_BYTE;
      addressHigh <= '0;
    end else if (wrTaken) begin
      if (link.regSel == PFSA_ADDR_LO) addressLow <= link.regWdata;
      if (link.regSel == PFSA_ADDR_HI) begin
        addressHigh <= link.regWdata[AH-1:0];
      end
    end
  end

  // data pair: loaded by a finished read or by the core, else held
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dataLow <= `PFSA_RESET_BYTE;
      dataHigh <= '0;
    end else begin
      if (readDone) begin
        dataLow <= flashMem[wordIndex][7:0];
        dataHigh <= flashMem[wordIndex][13:8];
      end
      if (wrTaken && link.regSel == PFSA_DATA_LO) begin
        dataLow <= link.regWdata;
      end
      if (wrTaken && link.regSel == PFSA_DATA_HI) begin
        dataHigh <= link.regWdata[DH-1:0];
      end
    end
  end

  // control bits; triggers are set by the core, cleared by hardware
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      programSpaceSelect <= 1'b0;
      writeEnableBit <= 1'b0;
      readTrigger <= 1'b0;
      writeTrigger <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        programSpaceSelect <= link.regWdata[`PFSA_BIT_PSS];
        writeEnableBit <= link.regWdata[`PFSA_BIT_WRITE_ENABLE_BIT];
      end
      if (startRead) readTrigger <= 1'b1;
      else if (readDone) readTrigger <= 1'b0;
      if (startWrite) writeTrigger <= 1'b1;
      else if (progDone) writeTrigger <= 1'b0;
    end
  end

  // unlock pattern: any other register write breaks it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      unlockState <= PFSA_LOCKED;
    end else if (wrTaken) begin
      if (link.regSel != PFSA_UNLOCK) begin
        unlockState <= PFSA_LOCKED;
      end else if (link.regWdata == `PFSA_UNLOCK_FIRST) begin
        unlockState <= PFSA_GOT_55;
      end else if (link.regWdata == `PFSA_UNLOCK_SECOND
                   && unlockState == PFSA_GOT_55) begin
        unlockState <= PFSA_GOT_AA;
      end else begin
        unlockState <= PFSA_LOCKED;
      end
    end
  end

  // sequencer; write enable is not looked at once a write runs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= PFSA_IDLE;
      cnt <= 16'h0000;
    end else begin
      unique case (state)
        PFSA_IDLE: begin
          if (startRead) begin
            state <= PFSA_READ;
            cnt <= READ_LAST;
          end else if (startWrite) begin
            state <= PFSA_SETUP;
            cnt <= SETUP_LAST;
          end
        end
        PFSA_READ: begin
          if (readDone) state <= PFSA_IDLE;
          else cnt <= cnt - 16'h0001;
        end
        PFSA_SETUP: begin
          if (cnt == 16'h0000) begin
            state <= PFSA_PROG;
            cnt <= PROG_LAST;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        PFSA_PROG: begin
          if (progDone) state <= PFSA_IDLE;
          else cnt <= cnt - 16'h0001;
        end
      endcase
    end
  end

  // stall the core for exactly the programming interval
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      link.coreStall <= 1'b0;
      progBusy <= 1'b0;
    end else begin
      if (state == PFSA_SETUP && cnt == 16'h0000) begin
        link.coreStall <= 1'b1;
      end else if (progDone) begin
        link.coreStall <= 1'b0;
      end
      if (startWrite) progBusy <= 1'b1;
      else if (progDone) progBusy <= 1'b0;
    end
  end

  // flash array: the word lands when the interval ends
  always_ff @(posedge core_clk) begin
    if (progDone) flashMem[wordIndex] <= {dataHigh, dataLow};
  end

  // read answers and refused-write indication
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      link.regRdata <= `PFSA_RESET_BYTE;
      link.rdValid <= 1'b0;
      writeBlocked <= 1'b0;
    end else begin
      link.rdValid <= rdTaken;
      if (rdTaken) begin
        link.regRdata <= readMux(link.regSel, addressLow, addressHigh,
                                 dataLow, dataHigh,
                                 ctrlByte(programSpaceSelect,
                                          writeEnableBit, writeTrigger,
                                          readTrigger));
      end
      writeBlocked <= tryWrite && !startWrite;
    end
  end

endmodule : pfsa_device

// File: verilog/pfsa_link_if.sv
// Purpose: register link between the core and the flash sequencer
// Assumes: an access is taken on an edge where it shows and no stall
// Notes: the core holds a stalled access until the stall drops
`timescale 1ns/1ps

interface pfsa_link_if;
  import pfsa_pkg::*;

  logic       regWr;
  logic       regRd;
  pfsa_sel_t  regSel;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       rdValid;
  logic       coreStall;

  modport dev (
    input  regWr,
    input  regRd,
    input  regSel,
    input  regWdata,
    output regRdata,
    output rdValid,
    output coreStall
  );

  modport core (
    output regWr,
    output regRd,
    output regSel,
    output regWdata,
    input  regRdata,
    input  rdValid,
    input  coreStall
  );

endinterface : pfsa_link_if

// File: verilog/pfsa_pkg.sv
// Purpose: shared types of the flash self-access link
// Assumes: constants header included alongside
// Notes: none
`include "pfsa_consts.svh"

package pfsa_pkg;

  typedef enum logic [2:0] {
    PFSA_ADDR_LO = `PFSA_SEL_ADDR_LO,
    PFSA_ADDR_HI = `PFSA_SEL_ADDR_HI,
    PFSA_DATA_LO = `PFSA_SEL_DATA_LO,
    PFSA_DATA_HI = `PFSA_SEL_DATA_HI,
    PFSA_CTRL    = `PFSA_SEL_CTRL,
    PFSA_UNLOCK  = `PFSA_SEL_UNLOCK
  } pfsa_sel_t;

  typedef enum logic [1:0] {
    PFSA_IDLE  = 2'h0,
    PFSA_READ  = 2'h1,
    PFSA_SETUP = 2'h2,
    PFSA_PROG  = 2'h3
  } pfsa_state_t;

  typedef enum logic [1:0] {
    PFSA_LOCKED = 2'h0,
    PFSA_GOT_55 = 2'h1,
    PFSA_GOT_AA = 2'h2
  } pfsa_unlock_t;

  typedef enum logic [1:0] {
    PFSA_OP_NOP  = 2'h0,
    PFSA_OP_WR   = 2'h1,
    PFSA_OP_RD   = 2'h2,
    PFSA_OP_DONE = 2'h3
  } pfsa_op_t;

  typedef struct packed {
    pfsa_op_t  op;
    pfsa_sel_t sel;
    logic [7:0] data;
  } pfsa_act_t;

endpackage : pfsa_pkg
